// *** rtl/sync_fault_status_recorder.sv ***
// Synchronous fault status and address recorder with overwrite arbitration
// Function
// - Sort faults: instruction, data, translation (I/D).
// - Instruction fault replaces only instruction status.
// - Data fault replaces instruction, never translation.
// - Translation replaces I/D; never itself replaced.
// - Overwrite flag when held status is replaced, except by a data-side fault over instruction.
// - Set overwrite when pending instruction trap first.
// - Level field holds walk level 0 to 3.
// - Access type from store, space, supervisor.
// - Fault type codes 0 to 5 only.
// - Translation on walk error, reserved, last-level pointer.
// - Invalid entry gives invalid address fault.
// - Page entry permission table gives fault type.
// - Copy-back walk error sets copy-back flag.
// - Address valid for data and translation faults.
// - Record bus error, timeout, uncorrectable flags.
// - Record only highest priority fault type.
// - Reset clears flags, type, valid, overwrite.
// - Reading status clears all status bits.
// - Instruction-space alternate loads count as instruction.
`timescale 1ns/1ps
`default_nettype none
`include "sync_fault_map.svh"
module sync_fault_status_recorder (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Register read port from the processor
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_space_ident,
  input wire logic [15:0] i_reg_addr,
  output logic [31:0] o_reg_rd_data,
  output logic o_reg_rd_valid,
  // Fault report from the cache controller and table walker
  input wire logic i_fault_valid,
  input wire logic i_fault_is_data,
  input wire logic [5:0] i_fault_space_ident,
  input wire logic i_acc_store,
  input wire logic i_acc_instr_space,
  input wire logic i_acc_super,
  input wire logic [31:0] i_fault_addr,
  input wire logic i_fault_addr_ok,
  input wire logic i_walk_active,
  input wire logic [1:0] i_walk_level,
  input wire logic [1:0] i_entry_type_code,
  input wire logic i_walk_ext_err,
  input wire logic i_perm_check,
  input wire logic [2:0] i_access_perm_code,
  input wire logic i_bus_err_flag,
  input wire logic i_bus_timeout_flag,
  input wire logic i_uncorrectable_err,
  input wire logic i_copyback_walk_fault,
  // Live status for observation
  output logic [31:0] o_sync_fault_status,
  output logic [31:0] o_sync_fault_addr
);
  import sync_fault_pkg::*;

  typedef struct packed {
    fault_cls_t cls;
    logic overwrite_flag;
    logic fault_addr_valid;
    logic [2:0] fault_type_field;
    logic [2:0] access_type_field;
    logic [1:0] level;
    logic bus_err_flag;
    logic bus_timeout_flag;
    logic uncorrectable_err;
    logic copyback_walk_fault;
    logic [31:0] sync_fault_addr;
    logic [31:0] rd_data;
    logic rd_valid;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [2:0] new_ft;
  logic new_trans;
  logic [2:0] new_at;
  logic is_instr;
  logic bus_any;
  fault_cls_t new_cls;
  fault_cls_t base_cls;
  logic rd_status;
  logic rd_addr;
  logic allow;
  logic ow_new;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////
  // Fault classification
  assign new_at = {i_acc_store, i_acc_instr_space, i_acc_super};
  assign bus_any = i_bus_err_flag | i_bus_timeout_flag | i_uncorrectable_err;
  // Alternate loads in instruction space behave as instruction faults
  assign is_instr = ~i_fault_is_data
    | (i_fault_space_ident == `SF_SPACE_UINSTR)
    | (i_fault_space_ident == `SF_SPACE_SINSTR);

  fault_type_resolver u_resolver (
    .i_walk_active(i_walk_active),
    .i_walk_level(i_walk_level),
    .i_entry_type_code(i_entry_type_code),
    .i_walk_ext_err(i_walk_ext_err),
    .i_perm_check(i_perm_check),
    .i_access_perm_code(i_access_perm_code),
    .i_access_type_field(new_at),
    .i_bus_any(bus_any),
    .o_fault_type_field(new_ft),
    .o_is_trans(new_trans)
  );

  // Class of the incoming fault
  always_comb begin
    if (new_trans) begin
      new_cls = CLS_TRANS;
    end else if (is_instr) begin
      new_cls = CLS_INSTR;
    end else begin
      new_cls = CLS_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  assign rd_status = i_reg_rd && i_reg_space_ident == `SF_SPACE_REGS && i_reg_addr == `SF_ADDR_STATUS;
  assign rd_addr = i_reg_rd && i_reg_space_ident == `SF_SPACE_REGS && i_reg_addr == `SF_ADDR_FADDR;
  // A read clears first, so a coinciding fault lands on an empty slot
  assign base_cls = rd_status ? CLS_NONE : cur.cls;

  // Overwrite arbitration by held class and order of arrival
  always_comb begin
    allow = 1'b0;
    ow_new = 1'b0;
    case (base_cls)
      CLS_NONE: begin
        allow = 1'b1;
        ow_new = 1'b0;
      end
      CLS_INSTR: begin
        allow = 1'b1;
        // Pending instruction trap is taken before a later instruction-side fault
        ow_new = (new_cls == CLS_INSTR) | ((new_cls == CLS_TRANS) & is_instr);
      end
      CLS_DATA: begin
        // Instruction fault must not replace data status
        allow = (new_cls != CLS_INSTR);
        ow_new = (new_cls != CLS_INSTR);
      end
      CLS_TRANS: begin
        allow = 1'b0;
        ow_new = 1'b0;
      end
      default: begin
        allow = 1'b0;
        ow_new = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word assembly, reserved bits read zero
  always_comb begin
    status_word = `SF_ZERO_WORD;
    status_word[`SF_BIT_OW] = cur.overwrite_flag;
    status_word[`SF_BIT_FAV] = cur.fault_addr_valid;
    status_word[`SF_FT_HI:`SF_FT_LO] = cur.fault_type_field;
    status_word[`SF_AT_HI:`SF_AT_LO] = cur.access_type_field;
    status_word[`SF_LVL_HI:`SF_LVL_LO] = cur.level;
    status_word[`SF_BIT_BE] = cur.bus_err_flag;
    status_word[`SF_BIT_TO] = cur.bus_timeout_flag;
    status_word[`SF_BIT_UC] = cur.uncorrectable_err;
    status_word[`SF_BIT_CBT] = cur.copyback_walk_fault;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_cur = cur;
    next_cur.rd_valid = rd_status | rd_addr;
    next_cur.rd_data = `SF_ZERO_WORD;
    if (rd_status) begin
      next_cur.rd_data = status_word;
    end else if (rd_addr) begin
      next_cur.rd_data = cur.sync_fault_addr;
    end
    // Read of the status word clears every status bit
    if (rd_status) begin
      next_cur.cls = CLS_NONE;
      next_cur.overwrite_flag = 1'b0;
      next_cur.fault_addr_valid = 1'b0;
      next_cur.fault_type_field = `SF_FT_NONE;
      next_cur.access_type_field = 3'h0;
      next_cur.level = 2'h0;
      next_cur.bus_err_flag = 1'b0;
      next_cur.bus_timeout_flag = 1'b0;
      next_cur.uncorrectable_err = 1'b0;
      next_cur.copyback_walk_fault = 1'b0;
    end
    // Capture in the detecting cycle; empty reports are ignored
    if (i_fault_valid && new_ft != `SF_FT_NONE && allow) begin
      next_cur.cls = new_cls;
      next_cur.overwrite_flag = ow_new;
      next_cur.fault_type_field = new_ft;
      next_cur.access_type_field = new_at;
      next_cur.level = i_walk_active ? i_walk_level : 2'h0;
      next_cur.bus_err_flag = i_bus_err_flag;
      next_cur.bus_timeout_flag = i_bus_timeout_flag;
      next_cur.uncorrectable_err = i_uncorrectable_err;
      next_cur.copyback_walk_fault = i_copyback_walk_fault & i_walk_active;
      next_cur.fault_addr_valid = (new_cls != CLS_INSTR) | i_fault_addr_ok;
      next_cur.sync_fault_addr = i_fault_addr;
    end
  end

  // State register; reset leaves no fault held
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_reg_rd_data = cur.rd_data;
  assign o_reg_rd_valid = cur.rd_valid;
  assign o_sync_fault_status = status_word;
  assign o_sync_fault_addr = cur.sync_fault_addr;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic fault_in;
  assign fault_in = i_fault_valid && new_ft != `SF_FT_NONE;

  chk_trans_held: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cur.cls == CLS_TRANS && !rd_status) |=> (cur.cls == CLS_TRANS && $stable(cur.sync_fault_addr)))
    else $error("translation status was replaced");

  chk_instr_no_replace: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cur.cls == CLS_DATA && fault_in && new_cls == CLS_INSTR && !rd_status) |=> $stable(cur.fault_type_field))
    else $error("instruction fault replaced data status");

  chk_data_over_instr: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cur.cls == CLS_INSTR && fault_in && new_cls == CLS_DATA && !rd_status)
    |=> (cur.cls == CLS_DATA && !cur.overwrite_flag))
    else $error("data fault did not replace instruction status cleanly");

  chk_ow_double_instr: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cur.cls == CLS_INSTR && fault_in && new_cls == CLS_INSTR && !rd_status) |=> cur.overwrite_flag)
    else $error("overwrite flag not set on double instruction fault");

  chk_ow_first_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cur.cls == CLS_NONE && fault_in && !rd_status) |=> !cur.overwrite_flag)
    else $error("overwrite flag set on single fault");

  chk_read_clears: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (rd_status && !i_fault_valid) |=> (status_word == `SF_ZERO_WORD && o_reg_rd_valid))
    else $error("status read did not clear status");

  chk_invalid_code: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (fault_in && base_cls == CLS_NONE && i_walk_active && i_entry_type_code == `SF_ET_INVALID && !new_trans)
    |=> cur.fault_type_field == `SF_FT_INVALID)
    else $error("invalid entry not recorded as invalid address");

  chk_trans_code: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (fault_in && base_cls != CLS_TRANS && i_walk_ext_err) |=> cur.fault_type_field == `SF_FT_TRANS)
    else $error("walk error not recorded as translation");

  chk_fav_data: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (fault_in && allow && new_cls != CLS_INSTR) |=> cur.fault_addr_valid)
    else $error("address valid missing for data or translation fault");

  chk_space_instr: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (fault_in && base_cls == CLS_NONE && !new_trans
      && (i_fault_space_ident == `SF_SPACE_UINSTR || i_fault_space_ident == `SF_SPACE_SINSTR))
    |=> cur.cls == CLS_INSTR)
    else $error("instruction space alternate load not classed as instruction");

  chk_ow_trans_instr: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cur.cls == CLS_INSTR && fault_in && new_cls == CLS_TRANS && is_instr && !rd_status)
    |=> (cur.cls == CLS_TRANS && cur.overwrite_flag))
    else $error("overwrite flag not set on instruction side translation over instruction");

  chk_ow_trans_data: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cur.cls == CLS_INSTR && fault_in && new_cls == CLS_TRANS && !is_instr && !rd_status)
    |=> (cur.cls == CLS_TRANS && !cur.overwrite_flag))
    else $error("overwrite flag set on data side translation over instruction");

  chk_ow_data_trans: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cur.cls == CLS_DATA && fault_in && new_cls == CLS_TRANS && !rd_status)
    |=> (cur.cls == CLS_TRANS && cur.overwrite_flag))
    else $error("translation over data did not replace with overwrite flag");

  chk_level_walk: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (fault_in && allow && i_walk_active)
    |=> (cur.level == $past(i_walk_level)))
    else $error("level field does not hold the walk level");

  chk_bus_flags: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (fault_in && allow) |=> (cur.bus_err_flag == $past(i_bus_err_flag)
      && cur.bus_timeout_flag == $past(i_bus_timeout_flag) && cur.uncorrectable_err == $past(i_uncorrectable_err)))
    else $error("bus outcome flags not recorded with the fault");

  chk_read_fault_same: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (rd_status && fault_in)
    |=> (cur.fault_type_field == $past(new_ft) && o_reg_rd_valid))
    else $error("fault coinciding with status read was lost");
endmodule
`default_nettype wire

// *** rtl/sync_fault_map.svh ***
// Offsets, field positions, codes and tables of the synchronous fault recorder
`ifndef SYNC_FAULT_MAP_SVH
`define SYNC_FAULT_MAP_SVH

// Register access space and register addresses
`define SF_SPACE_REGS 6'h04
`define SF_ADDR_STATUS 16'h0300
`define SF_ADDR_FADDR 16'h0400
`define SF_SPACE_UINSTR 6'h08
`define SF_SPACE_SINSTR 6'h09

// Status word field positions
`define SF_BIT_OW 0
`define SF_BIT_FAV 1
`define SF_FT_LO 2
`define SF_FT_HI 4
`define SF_AT_LO 5
`define SF_AT_HI 7
`define SF_LVL_LO 8
`define SF_LVL_HI 9
`define SF_BIT_BE 10
`define SF_BIT_TO 11
`define SF_BIT_UC 12
`define SF_BIT_CBT 13

// Fault type codes
`define SF_FT_NONE 3'h0
`define SF_FT_INVALID 3'h1
`define SF_FT_PROT 3'h2
`define SF_FT_PRIV 3'h3
`define SF_FT_TRANS 3'h4
`define SF_FT_BUS 3'h5

// Entry type codes and deepest table level
`define SF_ET_INVALID 2'h0
`define SF_ET_POINTER 2'h1
`define SF_ET_PAGE 2'h2
`define SF_ET_RESERVED 2'h3
`define SF_LEVEL_LAST 2'h3

// Permission outcome per access type (16 bits each, type 7 on top), 2 bits per permission code
`define SF_PERM_TABLE 128'h2A2A_FA2A_2222_FA22_080A_F80A_0200_F200
`define SF_PERM_ROW 16

// Reset values
`define SF_ZERO_WORD 32'h0000_0000
`endif

// *** rtl/sync_fault_pkg.sv ***
// Types shared by the synchronous fault recorder
package sync_fault_pkg;
  // Class of the fault whose status is held
  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_INSTR,
    CLS_DATA,
    CLS_TRANS
  } fault_cls_t;
endpackage

// *** rtl/fault_type_resolver.sv ***
// Picks the single highest priority fault type for one fault occurrence
`timescale 1ns/1ps
`default_nettype none
`include "sync_fault_map.svh"
module fault_type_resolver (
  input wire logic i_walk_active,
  input wire logic [1:0] i_walk_level,
  input wire logic [1:0] i_entry_type_code,
  input wire logic i_walk_ext_err,
  input wire logic i_perm_check,
  input wire logic [2:0] i_access_perm_code,
  input wire logic [2:0] i_access_type_field,
  input wire logic i_bus_any,
  output logic [2:0] o_fault_type_field,
  output logic o_is_trans
);
  localparam logic [127:0] PERM = `SF_PERM_TABLE;
  logic [15:0] perm_row;
  logic [1:0] perm_res;
  logic cand_trans;
  logic cand_inv;

  ////////////////////////////////////////////////////////////////////////
  // Candidate causes
  assign cand_trans = i_walk_ext_err
    | (i_walk_active & (i_entry_type_code == `SF_ET_RESERVED))
    | (i_walk_active & (i_entry_type_code == `SF_ET_POINTER) & (i_walk_level == `SF_LEVEL_LAST));
  assign cand_inv = i_walk_active & (i_entry_type_code == `SF_ET_INVALID);
  // Permission outcome: 0 none, 2 protection, 3 privilege
  assign perm_row = PERM[i_access_type_field * `SF_PERM_ROW +: `SF_PERM_ROW];
  assign perm_res = perm_row[i_access_perm_code * 2 +: 2];
  assign o_is_trans = cand_trans;

  // Priority: translation, invalid, privilege, protection, bus
  always_comb begin
    o_fault_type_field = `SF_FT_NONE;
    if (cand_trans) begin
      o_fault_type_field = `SF_FT_TRANS;
    end else if (cand_inv) begin
      o_fault_type_field = `SF_FT_INVALID;
    end else if (i_perm_check && perm_res != 2'h0) begin
      o_fault_type_field = {1'b0, perm_res};
    end else if (i_bus_any) begin
      o_fault_type_field = `SF_FT_BUS;
    end
  end
endmodule
`default_nettype wire

// *** test/cpu_reg_master.sv ***
// Processor side model issuing register reads to the fault recorder
`timescale 1ns/1ps
`default_nettype none
module cpu_reg_master (
  input wire logic i_core_clk,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_valid,
  output logic o_rd,
  output logic [5:0] o_space_ident,
  output logic [15:0] o_addr
);
  // Idle between reads; space parked outside the register space
  initial begin
    o_rd = 1'b0;
    o_space_ident = 6'h00;
    o_addr = 16'hFFFF;
  end
  // One-cycle strobe; answer taken just after that edge
  task automatic rd(input logic [5:0] s, input logic [15:0] a, output logic [31:0] d, output logic v);
    @(posedge i_core_clk);
    o_rd <= 1'b1;
    o_space_ident <= s;
    o_addr <= a;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    o_space_ident <= 6'h00;
    o_addr <= ~a;
    #1;
    d = i_rd_data;
    v = i_rd_valid;
  endtask
endmodule
`default_nettype wire

// *** test/sync_fault_status_recorder_tb_top.sv ***
// Self-checking testbench of the synchronous fault recorder
`timescale 1ns/1ps
`default_nettype none
module sync_fault_status_recorder_tb_top;
  logic clk, rst_n, fv, fd, st, is, su, fok, wa, wx, pc, be, to, uc, cb, rd, rvld;
  logic [5:0] fsp, rsp;
  logic [1:0] wl, et;
  logic [2:0] acc;
  logic [15:0] radr;
  logic [31:0] fa, rdat, stat, faddr;
  int n_mismatch = 0;
  int checks = 0;
  // Permission outcome per access type, one nibble per permission code 0..7
  logic [31:0] prow [8] = '{32'h0000_2033, 32'h0000_2000, 32'h2200_0233, 32'h2200_0200,
                            32'h2020_2233, 32'h2020_2020, 32'h2220_2233, 32'h2220_2220};
  logic [2:0] e;

  sync_fault_status_recorder u_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_reg_rd(rd),
    .i_reg_space_ident(rsp), .i_reg_addr(radr), .o_reg_rd_data(rdat), .o_reg_rd_valid(rvld),
    .i_fault_valid(fv), .i_fault_is_data(fd), .i_fault_space_ident(fsp), .i_acc_store(st),
    .i_acc_instr_space(is), .i_acc_super(su), .i_fault_addr(fa), .i_fault_addr_ok(fok),
    .i_walk_active(wa), .i_walk_level(wl), .i_entry_type_code(et), .i_walk_ext_err(wx),
    .i_perm_check(pc), .i_access_perm_code(acc), .i_bus_err_flag(be), .i_bus_timeout_flag(to),
    .i_uncorrectable_err(uc), .i_copyback_walk_fault(cb), .o_sync_fault_status(stat),
    .o_sync_fault_addr(faddr));
  cpu_reg_master u_cpu (.i_core_clk(clk), .i_rd_data(rdat), .i_rd_valid(rvld), .o_rd(rd),
    .o_space_ident(rsp), .o_addr(radr));

  ////////////////////////////////////////////////////////////////////////////
  // Checking and stimulus helpers
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  // Expected status word in the recorder's bit layout
  function automatic logic [31:0] sw(input logic ow, input logic av, input logic [2:0] ft,
                                     input logic [2:0] at, input logic [1:0] l, input logic [3:0] f);
    return {18'h0, f, l, at, ft, av, ow};
  endfunction
  // One fault pulse; f packs walk, copy-back, uncorrectable, timeout, bus error
  task automatic flt(input logic d, input logic [2:0] at, input logic [1:0] l, input logic [1:0] t,
                     input logic x, input logic p, input logic [2:0] a, input logic [4:0] f);
    @(posedge clk);
    fv <= 1'b1;
    {fd, st, is, su, wl, et, wx, pc, acc, wa, cb, uc, to, be} <= {d, at, l, t, x, p, a, f};
    fa <= fa + 32'h0000_0104;
    @(posedge clk);
    fv <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [5:0] s, input logic [15:0] a, input logic [31:0] x, input logic ev);
    logic [31:0] d;
    logic v;
    u_cpu.rd(s, a, d, v);
    chk("rd_data", x, d);
    chk("rd_valid", {31'h0, ev}, {31'h0, v});
  endtask
  // Status read answers the held word and empties the register
  task automatic clr(input logic [31:0] x);
    rdchk(6'h04, 16'h0300, x, 1'b1);
    chk("status_cleared", 32'h0, stat);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a bound on the whole run
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    {rst_n, fv, fd, st, is, su, fok, wa, wx, pc, be, to, uc, cb, wl, et, acc} = '0;
    fsp = 6'h0B;
    fa = 32'h1000_0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("reset_status", 32'h0, stat);
    flt(1'b1, 3'd5, 2'd2, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    chk("fault_addr", fa, faddr);
    rdchk(6'h04, 16'h0400, fa, 1'b1);
    clr(sw(0, 1, 1, 5, 2, 0));
    rdchk(6'h04, 16'h0500, 32'h0, 1'b0);
    rdchk(6'h0A, 16'h0300, 32'h0, 1'b0);
    // Instruction then instruction: newer kept, overwrite flagged
    flt(1'b0, 3'd2, 2'd1, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    flt(1'b0, 3'd3, 2'd3, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    clr(sw(1, 0, 1, 3, 3, 0));
    flt(1'b0, 3'd2, 2'd1, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    flt(1'b1, 3'd4, 2'd0, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    clr(sw(0, 1, 1, 4, 0, 0));
    flt(1'b1, 3'd0, 2'd1, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    flt(1'b0, 3'd2, 2'd2, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    clr(sw(0, 1, 1, 0, 1, 0));
    flt(1'b0, 3'd2, 2'd1, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    flt(1'b0, 3'd3, 2'd2, 2'd3, 1'b0, 1'b0, 3'd0, 5'h10);
    clr(sw(1, 1, 4, 3, 2, 0));
    flt(1'b0, 3'd2, 2'd1, 2'd2, 1'b1, 1'b0, 3'd0, 5'h10);
    flt(1'b1, 3'd0, 2'd0, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    flt(1'b0, 3'd3, 2'd2, 2'd3, 1'b0, 1'b0, 3'd0, 5'h10);
    clr(sw(0, 1, 4, 2, 1, 0));
    flt(1'b0, 3'd2, 2'd1, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    flt(1'b1, 3'd1, 2'd3, 2'd1, 1'b0, 1'b0, 3'd0, 5'h10);
    clr(sw(0, 1, 4, 1, 3, 0));
    flt(1'b1, 3'd0, 2'd1, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    flt(1'b0, 3'd2, 2'd0, 2'd3, 1'b0, 1'b0, 3'd0, 5'h10);
    clr(sw(1, 1, 4, 2, 0, 0));
    // Alternate load in instruction space counts as an instruction fault
    fsp <= 6'h08;
    flt(1'b1, 3'd2, 2'd1, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    fsp <= 6'h0B;
    flt(1'b0, 3'd3, 2'd2, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    clr(sw(1, 0, 1, 3, 2, 0));
    flt(1'b1, 3'd4, 2'd2, 2'd0, 1'b1, 1'b0, 3'd0, 5'h18);
    clr(sw(0, 1, 4, 4, 2, 4'h8));
    for (int i = 0; i < 3; i++) begin
      flt(1'b1, 3'd1, 2'd0, 2'd2, 1'b0, 1'b0, 3'd0, 5'h10 | (5'h1 << i));
      clr(sw(0, 1, 5, 1, 0, 4'h1 << i));
    end
    // Priority among causes of one occurrence
    flt(1'b1, 3'd0, 2'd0, 2'd2, 1'b0, 1'b1, 3'd4, 5'h11);
    clr(sw(0, 1, 2, 0, 0, 1));
    flt(1'b1, 3'd0, 2'd1, 2'd0, 1'b0, 1'b1, 3'd6, 5'h10);
    clr(sw(0, 1, 1, 0, 1, 0));
    // Every access type against every permission code
    fok <= 1'b1;
    for (int t = 0; t < 8; t++) begin
      for (int a = 0; a < 8; a++) begin
        e = prow[t][(7 - a) * 4 +: 3];
        flt(~t[1], t[2:0], 2'd0, 2'd2, 1'b0, 1'b1, a[2:0], 5'h10);
        clr(e != 3'd0 ? sw(0, 1, e, t[2:0], 0, 0) : 32'h0);
      end
    end
    // Read and new fault on the same edge: old word out, new one kept
    flt(1'b1, 3'd1, 2'd1, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    fork
      rdchk(6'h04, 16'h0300, sw(0, 1, 1, 1, 1, 0), 1'b1);
      flt(1'b1, 3'd5, 2'd3, 2'd0, 1'b0, 1'b0, 3'd0, 5'h10);
    join
    clr(sw(0, 1, 1, 5, 3, 0));
    print_verdict();
  end
endmodule
`default_nettype wire
